// ==== verilog/compat_defs.svh ====
// constants for the legacy compatibility register block
// assumes an 8-bit host i/o port interface with a 16-bit port address
`ifndef COMPAT_DEFS_SVH
`define COMPAT_DEFS_SVH
`define PORT_SEQ_IDX 16'h03c4
`define PORT_SEQ_DAT 16'h03c5
`define PORT_CRT_IDX_MONO 16'h03b4
`define PORT_CRT_DAT_MONO 16'h03b5
`define PORT_CRT_IDX_COL 16'h03d4
`define PORT_CRT_DAT_COL 16'h03d5
`define PORT_STAT1_MONO 16'h03ba
`define PORT_STAT1_COL 16'h03da
`define PORT_GFX_IDX 16'h03ce
`define PORT_GFX_DAT 16'h03cf
`define PORT_ATT_A 16'h03c0
`define PORT_ATT_B 16'h03c1
`define SEQ_FONT 3'h3
`define SEQ_MEM 3'h4
`define CRT_HTOTAL 5'h00
`define CRT_HBEND 5'h03
`define CRT_HREND 5'h05
`define CRT_VTOTAL 5'h06
`define CRT_HIGH 5'h07
`define CRT_PRESET 5'h08
`define CRT_HEIGHT 5'h09
`define CRT_CUR_FIRST 5'h0a
`define CRT_CUR_LAST 5'h0b
`define CRT_VRSTART 5'h10
`define CRT_VREND 5'h11
`define CRT_ULINE 5'h14
`define CRT_VBEND 5'h16
`define CRT_MODE 5'h17
`define GFX_RMAP 4'h4
`define GFX_MODE 4'h5
`define ATT_MODE 5'h10
`define ATT_BORDER 5'h11
`define ATT_PLANE 5'h12
`define HTOTAL_BIAS 9'h002
`endif

// ==== verilog/compat_pkg.sv ====
// types shared by the legacy compatibility register block
// assumes compat_defs.svh holds the numeric constants
package compat_pkg;
   typedef enum logic [1:0] {
      WR_MODE_0 = 2'b00,
      WR_MODE_1 = 2'b01,
      WR_MODE_2 = 2'b10
   } write_mode_t;
endpackage : compat_pkg

// ==== verilog/legacy_display_compat_regs.sv ====
// legacy compatibility register set of the display controller
// assumes host i/o strobes are one mclk pulse, synchronous, and the
// display pipeline supplies a character-clock enable and raster counters
// How it works
// (RULE_01) map bits 3:2 pick font region A
// (RULE_02) map bits 1:0 pick font region B
// (RULE_03) attribute bit 3 chooses A or B
// (RULE_04) memory-mode bit 0 selects text mode
// (RULE_05) crt index uses bits 4:0 only
// (RULE_06) horizontal total is characters minus two
// (RULE_07) display enable skewed 0 to 3 chars
// (RULE_08) blanking ends on low-five count match
// (RULE_09) retrace-end bit 7 picks odd start address
// (RULE_10) vertical total is frame length low byte
// (RULE_11) cursor skew codes give 0,0,1,2 chars
// (RULE_12) cursor end is last row plus one
// (RULE_13) index 10/11 reads return light pen
// (RULE_14) bit 5 floats the interrupt output
// (RULE_15) bit 4 clears or arms interrupt latch; the code clears it only when bit 5 is also low
// (RULE_16) underline on programmed row plus one
// (RULE_17) read map selects host read plane
// (RULE_18) write mode code 3 acts as 1
// (RULE_19) palette bits drive six colour outputs
// (RULE_20) border uses overscan colour bits
// (RULE_21) plane enable muxes colours into status
// (RULE_22) crt data port at mono or colour address
// (RULE_23) attribute ports 3c0 and 3c1 identical
// (RULE_24) data writes hit only selected register
`timescale 1ns/1ps
`include "compat_defs.svh"
module legacy_display_compat_regs (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   output logic [7:0] io_rdata,
   input wire logic colour_io_mode,
   input wire logic char_tick,
   input wire logic [7:0] h_char_count,
   input wire logic [4:0] row_scan,
   input wire logic raw_display_enable,
   input wire logic raw_cursor,
   input wire logic vdisp_end,
   input wire logic [7:0] attr_code,
   input wire logic [3:0] pixel_index,
   input wire logic border_active,
   input wire logic [15:0] light_pen_addr,
   input wire logic [7:0] plane_data0,
   input wire logic [7:0] plane_data1,
   input wire logic [7:0] plane_data2,
   input wire logic [7:0] plane_data3,
   output logic [1:0] font_region,
   output logic text_mode,
   output logic [8:0] chars_per_line,
   output logic [7:0] frame_lines_low,
   output logic [7:0] retrace_start_low,
   output logic hblank_end,
   output logic odd_start_addr,
   output logic display_enable,
   output logic cursor_out,
   output logic cursor_last_row,
   output logic underline_row_hit,
   output logic [1:0] plane_read_sel,
   output compat_pkg::write_mode_t write_mode,
   output logic colour_out_blue,
   output logic colour_out_green,
   output logic colour_out_red,
   output logic colour_out_sec_blue,
   output logic colour_out_sec_green,
   output logic colour_out_sec_red,
   output logic irq_out,
   output logic irq_oe
);
   // =====================================================
   // port decode
   logic [15:0] crt_dat_port;
   logic [15:0] crt_idx_port;
   logic [15:0] stat1_port;
   logic att_hit;
   assign crt_dat_port = colour_io_mode ? `PORT_CRT_DAT_COL : `PORT_CRT_DAT_MONO; // [RULE_22]
   assign crt_idx_port = colour_io_mode ? `PORT_CRT_IDX_COL : `PORT_CRT_IDX_MONO;
   assign stat1_port = colour_io_mode ? `PORT_STAT1_COL : `PORT_STAT1_MONO;
   assign att_hit = (io_addr == `PORT_ATT_A) || (io_addr == `PORT_ATT_B); // [RULE_23]

   // =====================================================
   // index registers
   logic [2:0] seq_idx_q;
   logic [4:0] crt_register_pointer_q;
   logic [3:0] gfx_idx_q;
   logic [4:0] att_idx_q;
   logic att_flip_q;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         seq_idx_q <= 3'h0;
         crt_register_pointer_q <= 5'h00;
         gfx_idx_q <= 4'h0;
      end else if (io_wr) begin
         if (io_addr == `PORT_SEQ_IDX) seq_idx_q <= io_wdata[2:0];
         if (io_addr == crt_idx_port) crt_register_pointer_q <= io_wdata[4:0]; // [RULE_05]
         if (io_addr == `PORT_GFX_IDX) gfx_idx_q <= io_wdata[3:0];
      end
   end

   // attribute port alternates index and data; status port read resets it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         att_idx_q <= 5'h00;
         att_flip_q <= 1'b0;
      end else if (io_rd && io_addr == stat1_port) begin
         att_flip_q <= 1'b0;
      end else if (io_wr && att_hit) begin
         att_flip_q <= ~att_flip_q;
         if (!att_flip_q) att_idx_q <= io_wdata[4:0];
      end
   end

   // =====================================================
   // data registers
   logic [7:0] font_region_select_q;
   logic [7:0] plane_memory_mode_q;
   logic [7:0] line_length_total_q;
   logic [7:0] line_blank_end_q;
   logic [7:0] line_retrace_end_q;
   logic [7:0] frame_length_total_q;
   logic [7:0] crt_high_bits_q;
   logic [7:0] initial_row_scan_q;
   logic [7:0] character_height_q;
   logic [7:0] cursor_first_row_q;
   logic [7:0] cursor_last_row_skew_q;
   logic [7:0] frame_retrace_start_q;
   logic [7:0] frame_retrace_end_irq_q;
   logic [7:0] underline_row_q;
   logic [7:0] frame_blank_end_q;
   logic [7:0] crt_operating_control_q;
   logic [7:0] read_plane_select_q;
   logic [7:0] graphics_write_mode_q;
   logic [5:0] colour_lookup_entries_q [16];
   logic [7:0] attribute_operating_control_q;
   logic [7:0] border_colour_q;
   logic [7:0] plane_enable_status_mux_q;
   logic seq_wr;
   logic crt_wr;
   logic gfx_wr;
   logic att_wr;
   assign seq_wr = io_wr && io_addr == `PORT_SEQ_DAT;
   assign crt_wr = io_wr && io_addr == crt_dat_port;
   assign gfx_wr = io_wr && io_addr == `PORT_GFX_DAT;
   assign att_wr = io_wr && att_hit && att_flip_q;

   // unused bits are dropped on write so they always hold zero; host reads never return these registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         font_region_select_q <= 8'h00;
         plane_memory_mode_q <= 8'h00;
      end else if (seq_wr) begin
         case (seq_idx_q) // [RULE_24]
            `SEQ_FONT: font_region_select_q <= {4'h0, io_wdata[3:0]};
            `SEQ_MEM: plane_memory_mode_q <= {5'h00, io_wdata[2:0]};
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         line_length_total_q <= 8'h00;
         line_blank_end_q <= 8'h00;
         line_retrace_end_q <= 8'h00;
         frame_length_total_q <= 8'h00;
         crt_high_bits_q <= 8'h00;
         initial_row_scan_q <= 8'h00;
         character_height_q <= 8'h00;
         cursor_first_row_q <= 8'h00;
         cursor_last_row_skew_q <= 8'h00;
         frame_retrace_start_q <= 8'h00;
         underline_row_q <= 8'h00;
         frame_blank_end_q <= 8'h00;
         crt_operating_control_q <= 8'h00;
      end else if (crt_wr) begin
         case (crt_register_pointer_q) // [RULE_24]
            `CRT_HTOTAL: line_length_total_q <= io_wdata;
            `CRT_HBEND: line_blank_end_q <= {1'b0, io_wdata[6:0]};
            `CRT_HREND: line_retrace_end_q <= io_wdata;
            `CRT_VTOTAL: frame_length_total_q <= io_wdata;
            `CRT_HIGH: crt_high_bits_q <= {3'h0, io_wdata[4:0]};
            `CRT_PRESET: initial_row_scan_q <= {3'h0, io_wdata[4:0]};
            `CRT_HEIGHT: character_height_q <= {3'h0, io_wdata[4:0]};
            `CRT_CUR_FIRST: cursor_first_row_q <= {3'h0, io_wdata[4:0]};
            `CRT_CUR_LAST: cursor_last_row_skew_q <= {1'b0, io_wdata[6:0]};
            `CRT_VRSTART: frame_retrace_start_q <= io_wdata; // [RULE_13]
            `CRT_ULINE: underline_row_q <= {3'h0, io_wdata[4:0]};
            `CRT_VBEND: frame_blank_end_q <= {3'h0, io_wdata[4:0]};
            `CRT_MODE: crt_operating_control_q <= {io_wdata[7:5], 1'b0, io_wdata[3:0]};
            default: ;
         endcase
      end
   end

   logic vrend_wr;
   assign vrend_wr = crt_wr && crt_register_pointer_q == `CRT_VREND;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) frame_retrace_end_irq_q <= 8'h00;
      else if (vrend_wr) frame_retrace_end_irq_q <= {2'h0, io_wdata[5:0]};
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         read_plane_select_q <= 8'h00;
         graphics_write_mode_q <= 8'h00;
      end else if (gfx_wr) begin
         case (gfx_idx_q) // [RULE_24]
            `GFX_RMAP: read_plane_select_q <= {5'h00, io_wdata[2:0]};
            `GFX_MODE: graphics_write_mode_q <= {2'h0, io_wdata[5:0]};
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) colour_lookup_entries_q[i] <= 6'h00;
         attribute_operating_control_q <= 8'h00;
         border_colour_q <= 8'h00;
         plane_enable_status_mux_q <= 8'h00;
      end else if (att_wr) begin
         if (att_idx_q[4] == 1'b0) colour_lookup_entries_q[att_idx_q[3:0]] <= io_wdata[5:0];
         else begin
            case (att_idx_q) // [RULE_24]
               `ATT_MODE: attribute_operating_control_q <= {4'h0, io_wdata[3:0]};
               `ATT_BORDER: border_colour_q <= {2'h0, io_wdata[5:0]};
               `ATT_PLANE: plane_enable_status_mux_q <= {2'h0, io_wdata[5:0]};
               default: ;
            endcase
         end
      end
   end

   // =====================================================
   // interrupt latch; a set in the same cycle as a clear wins
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) irq_out <= 1'b0;
      else if (vdisp_end && frame_retrace_end_irq_q[4]) irq_out <= 1'b1; // [RULE_15]
      else if (vrend_wr && !io_wdata[4] && !io_wdata[5]) irq_out <= 1'b0; // [RULE_15]
   end
   assign irq_oe = ~frame_retrace_end_irq_q[5]; // [RULE_14]

   // =====================================================
   // timing decode
   assign font_region = attr_code[3] ? font_region_select_q[3:2] // [RULE_03] [RULE_01]
                                     : font_region_select_q[1:0]; // [RULE_02]
   assign text_mode = plane_memory_mode_q[0]; // [RULE_04]
   assign chars_per_line = {1'b0, line_length_total_q} + `HTOTAL_BIAS; // [RULE_06]
   assign frame_lines_low = frame_length_total_q; // [RULE_10]
   assign retrace_start_low = frame_retrace_start_q;
   assign hblank_end = h_char_count[4:0] == line_blank_end_q[4:0]; // [RULE_08]
   assign odd_start_addr = line_retrace_end_q[7]; // [RULE_09]
   assign cursor_last_row = (row_scan + 5'h01) == cursor_last_row_skew_q[4:0]; // [RULE_12]
   assign underline_row_hit = row_scan == (underline_row_q[4:0] + 5'h01); // [RULE_16]
   assign plane_read_sel = read_plane_select_q[1:0]; // [RULE_17]
   assign write_mode = graphics_write_mode_q[1:0] == 2'b11 ? compat_pkg::WR_MODE_1 // [RULE_18]
                     : compat_pkg::write_mode_t'(graphics_write_mode_q[1:0]);

   // skew pipelines advance on character clocks
   logic [2:0] de_pipe_q;
   logic [1:0] cur_pipe_q;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         de_pipe_q <= 3'h0;
         cur_pipe_q <= 2'h0;
      end else if (char_tick) begin
         de_pipe_q <= {de_pipe_q[1:0], raw_display_enable};
         cur_pipe_q <= {cur_pipe_q[0], raw_cursor};
      end
   end
   logic cur_sel;
   always_comb begin
      case (cursor_last_row_skew_q[6:5]) // [RULE_11]
         2'b10: cur_sel = cur_pipe_q[0];
         2'b11: cur_sel = cur_pipe_q[1];
         default: cur_sel = raw_cursor;
      endcase
   end
   wire logic [3:0] de_taps = {de_pipe_q, raw_display_enable};
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         display_enable <= 1'b0;
         cursor_out <= 1'b0;
      end else begin
         display_enable <= de_taps[line_blank_end_q[6:5]]; // [RULE_07]
         cursor_out <= cur_sel; // [RULE_11]
      end
   end

   // =====================================================
   // colour outputs
   logic [5:0] colour_q;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) colour_q <= 6'h00;
      else if (border_active) colour_q <= border_colour_q[5:0]; // [RULE_20]
      else colour_q <= colour_lookup_entries_q[pixel_index]; // [RULE_19]
   end
   assign {colour_out_sec_red, colour_out_sec_green, colour_out_sec_blue,
           colour_out_red, colour_out_green, colour_out_blue} = colour_q;

   logic [1:0] status_pair;
   always_comb begin
      case (plane_enable_status_mux_q[5:4]) // [RULE_21]
         2'b00: status_pair = {colour_q[2], colour_q[0]};
         2'b10: status_pair = {colour_q[3], colour_q[1]};
         default: status_pair = {colour_q[5], colour_q[4]};
      endcase
   end

   // =====================================================
   // host reads
   logic [7:0] plane_byte;
   always_comb begin
      case (read_plane_select_q[1:0])
         2'b00: plane_byte = plane_data0;
         2'b01: plane_byte = plane_data1;
         2'b10: plane_byte = plane_data2;
         default: plane_byte = plane_data3;
      endcase
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) io_rdata <= 8'h00;
      else if (io_rd) begin
         if (io_addr == crt_dat_port && crt_register_pointer_q == `CRT_VRSTART)
            io_rdata <= light_pen_addr[15:8]; // [RULE_13]
         else if (io_addr == crt_dat_port && crt_register_pointer_q == `CRT_VREND)
            io_rdata <= light_pen_addr[7:0]; // [RULE_13]
         else if (io_addr == stat1_port)
            io_rdata <= {2'h0, status_pair, 3'h0, ~raw_display_enable};
         else if (io_addr == `PORT_GFX_DAT)
            io_rdata <= plane_byte; // [RULE_17]
         else io_rdata <= 8'h00;
      end
   end
   // =====================================================
   // checks
   property p_irq_clear;
      @(posedge mclk) disable iff (rst)
      (vrend_wr && !io_wdata[4] && !io_wdata[5] && !vdisp_end) |=> !irq_out;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("latch not cleared"); // [RULE_15]
   property p_irq_set;
      @(posedge mclk) disable iff (rst)
      (vdisp_end && frame_retrace_end_irq_q[4]) |=> irq_out;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("latch not set"); // [RULE_15]
   property p_wmode;
      @(posedge mclk) disable iff (rst)
      (graphics_write_mode_q[1:0] == 2'b11) |-> write_mode == compat_pkg::WR_MODE_1;
   endproperty
   a_wmode: assert property (p_wmode) else $error("illegal write mode"); // [RULE_18]
   property p_border;
      @(posedge mclk) disable iff (rst) border_active |=> colour_q == $past(border_colour_q[5:0]);
   endproperty
   a_border: assert property (p_border) else $error("border colour wrong"); // [RULE_20]
   property p_att_toggle;
      @(posedge mclk) disable iff (rst) (io_wr && att_hit && !io_rd) |=> $changed(att_flip_q);
   endproperty
   a_att_toggle: assert property (p_att_toggle) else $error("attribute flip stuck"); // [RULE_23]
   property p_font_keep;
      @(posedge mclk) disable iff (rst) crt_wr |=> $stable(font_region_select_q);
   endproperty
   a_font_keep: assert property (p_font_keep) else $error("crt write hit font select"); // [RULE_24]
endmodule : legacy_display_compat_regs

// ==== sim/host_port_model.sv ====
// host processor model: one-cycle i/o strobes on the device's own port bus
// assumes the device samples strobes and address on the rising edge of mclk
`timescale 1ns/1ps
module host_port_model (
   input wire logic mclk,
   output logic [15:0] io_addr,
   output logic [7:0] io_wdata,
   output logic io_wr,
   output logic io_rd,
   input wire logic [7:0] io_rdata
);
   initial begin
      io_addr = 16'h0000;
      io_wdata = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
   end
   // ==========================================================
   // port cycles
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(posedge mclk);
      #1;
      io_wr = 1'b0;
      // a released data bus keeps no value, so do not leave the last one
      io_wdata = ~d;
      io_addr = ~a;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk);
      #1;
      io_addr = a;
      io_rd = 1'b1;
      @(posedge mclk);
      #1;
      io_rd = 1'b0;
      io_addr = ~a;
      @(posedge mclk);
      d = io_rdata;
   endtask : rd
   // index first, then data; the data write lands at wr's second edge, then one more edge passes
   task automatic put(input logic [15:0] ia, input logic [15:0] da,
                      input logic [7:0] i, input logic [7:0] d);
      wr(ia, i);
      wr(da, d);
      @(posedge mclk);
      #1;
   endtask : put
endmodule : host_port_model

// ==== sim/legacy_display_compat_regs_bench.sv ====
// self-checking bench for the legacy compatibility register block
// assumes host_port_model drives the i/o strobes; raster inputs come from here
`timescale 1ns/1ps
module legacy_display_compat_regs_bench;
   logic mclk, rst, colour_io_mode, char_tick, raw_display_enable, raw_cursor;
   logic vdisp_end, border_active;
   logic [15:0] io_addr;
   logic [7:0] io_wdata, io_rdata, h_char_count, attr_code, d;
   logic io_wr, io_rd;
   logic [4:0] row_scan;
   logic [3:0] pixel_index;
   logic [1:0] font_region, plane_read_sel;
   logic [8:0] chars_per_line;
   logic [7:0] frame_lines_low, retrace_start_low;
   logic hblank_end, odd_start_addr, display_enable, cursor_out, cursor_last_row;
   logic underline_row_hit, text_mode, irq_out, irq_oe;
   logic c_b, c_g, c_r, c_sb, c_sg, c_sr;
   compat_pkg::write_mode_t write_mode;
   int num_errors = 0;
   int compares = 0;
   int n, b;
   logic [15:0] lpen = 16'hbe5a;
   host_port_model h (.mclk(mclk), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata));
   legacy_display_compat_regs uut (.mclk(mclk), .rst(rst), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
      .colour_io_mode(colour_io_mode), .char_tick(char_tick),
      .h_char_count(h_char_count), .row_scan(row_scan),
      .raw_display_enable(raw_display_enable), .raw_cursor(raw_cursor),
      .vdisp_end(vdisp_end), .attr_code(attr_code), .pixel_index(pixel_index),
      .border_active(border_active), .light_pen_addr(lpen),
      .plane_data0(8'h11), .plane_data1(8'h22), .plane_data2(8'h44),
      .plane_data3(8'h88), .font_region(font_region), .text_mode(text_mode),
      .chars_per_line(chars_per_line), .frame_lines_low(frame_lines_low),
      .retrace_start_low(retrace_start_low), .hblank_end(hblank_end),
      .odd_start_addr(odd_start_addr), .display_enable(display_enable),
      .cursor_out(cursor_out), .cursor_last_row(cursor_last_row),
      .underline_row_hit(underline_row_hit), .plane_read_sel(plane_read_sel),
      .write_mode(write_mode), .colour_out_blue(c_b), .colour_out_green(c_g),
      .colour_out_red(c_r), .colour_out_sec_blue(c_sb), .colour_out_sec_green(c_sg),
      .colour_out_sec_red(c_sr), .irq_out(irq_out), .irq_oe(irq_oe));
   // ==========================================================
   // clock, checking and closing
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   task automatic step(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : step
   // cycles from a raw rise to the skewed output; bounded wait
   task automatic lat(input bit cur, output int cnt);
      cnt = 0;
      if (cur) raw_cursor = 1'b1;
      else raw_display_enable = 1'b1;
      while ((cur ? cursor_out : display_enable) !== 1'b1 && cnt < 20) begin
         step(1);
         cnt++;
      end
      if (cnt == 20) begin
         chk("skew_wait", 16'h1, 16'(cur ? cursor_out : display_enable));
         test_done();
      end
      raw_cursor = 1'b0;
      raw_display_enable = 1'b0;
      step(12);
   endtask : lat
   // ==========================================================
   // main sequence
   initial begin
      rst = 1'b1;
      {colour_io_mode, char_tick, raw_display_enable, raw_cursor} = 4'h8;
      {vdisp_end, border_active} = 2'b00;
      h_char_count = 8'h00;
      row_scan = 5'h00;
      attr_code = 8'h00;
      pixel_index = 4'h5;
      repeat (12) @(posedge mclk);
      #1;
      rst = 1'b0;
      char_tick = 1'b1;
      chk("irq_oe_rst", 16'h1, irq_oe);
      h.put(16'h03c4, 16'h03c5, 8'h03, 8'hfe);
      chk("font_b", 16'h2, font_region);
      attr_code = 8'h08;
      #1 chk("font_a", 16'h3, font_region);
      h.put(16'h03c4, 16'h03c5, 8'h04, 8'h01);
      chk("text", 16'h1, text_mode);
      h.put(16'h03c4, 16'h03c5, 8'h04, 8'h00);
      chk("gfx", 16'h0, text_mode);
      h.put(16'h03d4, 16'h03d5, 8'he0, 8'h50);
      chk("htotal", 16'h052, chars_per_line);
      colour_io_mode = 1'b0;
      h.put(16'h03b4, 16'h03b5, 8'h06, 8'h7f);
      h.put(16'h03d4, 16'h03d5, 8'h06, 8'h12);
      chk("vtotal", 16'h7f, frame_lines_low);
      chk("htotal_kept", 16'h052, chars_per_line);
      colour_io_mode = 1'b1;
      h.put(16'h03d4, 16'h03d5, 8'h03, 8'h05);
      h_char_count = 8'h25;
      #1 chk("hbl_hit", 16'h1, hblank_end);
      step(1);
      h_char_count = 8'h26;
      #1 chk("hbl_miss", 16'h0, hblank_end);
      chk("even", 16'h0, odd_start_addr);
      h.put(16'h03d4, 16'h03d5, 8'h05, 8'h80);
      chk("odd", 16'h1, odd_start_addr);
      h.put(16'h03d4, 16'h03d5, 8'h0b, 8'h06);
      row_scan = 5'h05;
      #1 chk("cur_last", 16'h1, cursor_last_row);
      chk("uline_miss", 16'h0, underline_row_hit);
      h.put(16'h03d4, 16'h03d5, 8'h14, 8'h03);
      row_scan = 5'h04;
      #1 chk("uline", 16'h1, underline_row_hit);
      chk("cur_other", 16'h0, cursor_last_row);
      h.put(16'h03d4, 16'h03d5, 8'h10, 8'h33);
      chk("vrs", 16'h33, retrace_start_low);
      h.rd(16'h03d5, d);
      chk("lpen_hi", lpen[15:8], d);
      h.wr(16'h03d4, 8'h11);
      h.rd(16'h03d5, d);
      chk("lpen_lo", lpen[7:0], d);
      h.put(16'h03d4, 16'h03d5, 8'h11, 8'h10);
      vdisp_end = 1'b1;
      step(1);
      vdisp_end = 1'b0;
      step(2);
      chk("irq_set", 16'h1, irq_out);
      chk("irq_drv", 16'h1, irq_oe);
      h.put(16'h03d4, 16'h03d5, 8'h11, 8'h00);
      chk("irq_clr", 16'h0, irq_out);
      h.put(16'h03d4, 16'h03d5, 8'h11, 8'h20);
      chk("irq_float", 16'h0, irq_oe);
      for (int k = 0; k < 4; k++) begin
         h.put(16'h03d4, 16'h03d5, 8'h03, {1'b0, k[1:0], 5'h05});
         lat(1'b0, n);
         if (k == 0) b = n;
         chk("de_skew", k[15:0], 16'(n - b));
      end
      for (int k = 0; k < 4; k++) begin
         h.put(16'h03d4, 16'h03d5, 8'h0b, {1'b0, k[1:0], 5'h06});
         lat(1'b1, n);
         if (k == 0) b = n;
         chk("cur_skew", (k < 2) ? 16'h0 : 16'(k - 1), 16'(n - b));
      end
      for (int k = 0; k < 4; k++) begin
         h.put(16'h03ce, 16'h03cf, 8'h04, 8'(k));
         chk("rmap", k[15:0], plane_read_sel);
         h.rd(16'h03cf, d);
         chk("rplane", 8'h11 << k, d);
         h.put(16'h03ce, 16'h03cf, 8'h05, 8'(k));
         chk("wmode", (k == 3) ? 16'h1 : k[15:0], write_mode);
      end
      h.rd(16'h03da, d);
      h.wr(16'h03c0, 8'h05);
      h.wr(16'h03c1, 8'h2a);
      step(3);
      chk("palette", 16'h2a, {c_sr, c_sg, c_sb, c_r, c_g, c_b});
      h.put(16'h03c0, 16'h03c0, 8'h11, 8'h15);
      border_active = 1'b1;
      step(3);
      chk("border", 16'h15, {c_sr, c_sg, c_sb, c_r, c_g, c_b});
      border_active = 1'b0;
      for (int k = 0; k < 4; k++) begin
         h.put(16'h03c1, 16'h03c1, 8'h12, {2'b00, k[1:0], 4'h0});
         h.rd(16'h03da, d);
         b = (k == 0) ? 0 : (k == 2) ? 3 : 2;
         chk("status", {8'h00, 2'b00, 2'(b), 4'h1}, d);
      end
      test_done();
   end
   initial begin
      #1000000;
      num_errors++;
      test_done();
   end
endmodule : legacy_display_compat_regs_bench
